// [logic/smbhs_pkg.sv]
// smbhs_pkg: register map, reset values, field layouts and shared types of the smbus host block
package smbhs_pkg;
    // i/o register offsets
    localparam logic [7:0]  OFF_HOST_CMD  = 8'he8;
    localparam logic [7:0]  OFF_BLOCK     = 8'he9;
    localparam logic [7:0]  OFF_SDATA_LO  = 8'hea;
    localparam logic [7:0]  OFF_SDATA_HI  = 8'heb;
    localparam logic [7:0]  OFF_SADDR_LO  = 8'hec;
    localparam logic [7:0]  OFF_SADDR_HI  = 8'hed;
    localparam logic [7:0]  OFF_OWN_ADDR  = 8'hee;
    localparam logic [7:0]  OFF_MON_ADDR  = 8'hef;

    // values after reset
    localparam logic [7:0]  RST_HOST_CMD  = 8'h00;
    localparam logic [7:0]  RST_RDATA     = 8'h00;
    localparam logic [15:0] RST_SDATA     = 16'h0000;
    localparam logic [15:0] RST_SADDR     = 16'h0000;
    localparam logic [7:0]  RST_OWN_ADDR  = 8'h10;
    localparam logic [7:0]  RST_MON_ADDR  = 8'h10;
    localparam logic [5:0]  RST_COUNT     = 6'h00;

    // block fifo geometry
    localparam int          FIFO_DEPTH    = 32;
    localparam int          PTR_W         = 6;
    localparam logic [5:0]  FIFO_FULL_CNT = 6'h20;

    // field positions
    localparam int          DIR_BIT       = 0;
    localparam int          COUNT_MSB     = 5;
    localparam logic [4:0]  TEN_BIT_PFX   = 5'h1e;

    // one completed capture, handed from the link domain as a whole
    typedef struct packed {
        logic [15:0] data;
        logic [15:0] addr;
        logic        slave_hit;
        logic        mon_hit;
    } smbhs_cap_t;

    // position inside the snooped bus cycle
    typedef enum logic [2:0] {
        LK_IDLE,
        LK_ADDR,
        LK_CMD,
        LK_EXT,
        LK_DLO,
        LK_DHI,
        LK_REST
    } smbhs_lk_state_t;
endpackage

// [logic/smbhs_top.sv]
// smbhs_top: host command and block fifo registers plus host-as-slave and monitor capture
`timescale 1ns/1ns
`default_nettype none

module smbhs_top (
    input  wire logic          clk_i,
    input  wire logic          reset_i,
    input  wire logic          link_clk_i,
    input  wire logic [7:0]    io_addr_i,
    input  wire logic          io_wr_i,
    input  wire logic          io_rd_i,
    input  wire logic [7:0]    io_wdata_i,
    output logic      [7:0]    io_rdata_o,
    input  wire logic          host_busy_i,
    input  wire logic          host_go_req_i,
    input  wire logic [15:0]   host_data_i,
    input  wire logic          block_start_i,
    input  wire logic          block_error_i,
    output logic               host_go_o,
    output logic      [7:0]    host_command_o,
    output logic      [5:0]    block_count_o,
    output logic               tx_valid_o,
    output logic      [7:0]    tx_data_o,
    input  wire logic          tx_ready_i,
    input  wire logic          rx_valid_i,
    input  wire logic [7:0]    rx_data_i,
    output logic               rx_ready_o,
    input  wire logic          lk_start_i,
    input  wire logic          lk_byte_valid_i,
    input  wire logic [7:0]    lk_byte_i,
    input  wire logic          lk_stop_i,
    input  wire logic          lk_timeout_i,
    output logic               slave_match_flag_o,
    output logic               monitor_match_flag_o,
    input  wire logic          slave_flag_clr_i,
    input  wire logic          monitor_flag_clr_i
);
    import smbhs_pkg::*;

    logic [7:0]             cmd_r;
    logic [7:0]             own_r;
    logic [7:0]             mon_r;
    logic [15:0]            sdata_r;
    logic [15:0]            saddr_r;
    logic [7:0]             mem [FIFO_DEPTH];
    logic [PTR_W-1:0]       wptr_r;
    logic [PTR_W-1:0]       rptr_r;
    logic [PTR_W-1:0]       cnt;
    logic [PTR_W-1:0]       cnt_nxt;
    logic                   full;
    logic                   empty;
    logic                   flush;
    logic                   sw_ok;
    logic                   sw_push;
    logic                   sw_pop;
    logic                   rx_push;
    logic                   tx_pop;
    logic                   push;
    logic                   pop;
    logic [7:0]             push_d;
    logic [7:0]             pop_d;
    logic                   out_v_r;
    logic [7:0]             out_d_r;
    logic                   skid_v_r;
    logic [7:0]             skid_d_r;
    logic                   drain;
    logic                   rx_ready_r;
    logic                   rd_mode_r;
    logic                   req_s1_r;
    logic                   req_s2_r;
    logic                   req_s3_r;
    logic                   ack_tgl_r;
    logic                   cap_new;
    logic                   slv_flag_r;
    logic                   mon_flag_r;
    // link domain
    logic                   lrst_s1_r;
    logic                   lrst_s2_r;
    logic [6:0]             own_s1_r;
    logic [6:0]             own_s2_r;
    logic [6:0]             mon_s1_r;
    logic [6:0]             mon_s2_r;
    logic                   ack_s1_r;
    logic                   ack_s2_r;
    logic                   req_tgl_r;
    logic                   pending;
    smbhs_lk_state_t        lk_state_r;
    logic                   s_hit_r;
    logic                   m_hit_r;
    logic [15:0]            wk_addr_r;
    logic [15:0]            wk_data_r;
    smbhs_cap_t             cap_r;

    // one decode for every register select
    function automatic logic sel(input logic [7:0] a, input logic [7:0] off);
        sel = (a == off);
    endfunction

    // software block port access is only honoured while the host is idle
    assign sw_ok   = !host_busy_i;
    assign sw_push = io_wr_i && sel(io_addr_i, OFF_BLOCK) && sw_ok && !full;
    assign sw_pop  = io_rd_i && sel(io_addr_i, OFF_BLOCK) && sw_ok && !empty;
    assign rx_push = rx_valid_i && rx_ready_r && host_busy_i;
    assign tx_pop  = host_busy_i && !rd_mode_r && !empty && !skid_v_r;
    assign push    = sw_push || rx_push;
    assign pop     = sw_pop || tx_pop;
    assign push_d  = sw_push ? io_wdata_i : rx_data_i;
    assign pop_d   = mem[rptr_r[PTR_W-2:0]];
    assign cnt     = wptr_r - rptr_r;
    assign full    = (cnt == FIFO_FULL_CNT);
    assign empty   = (cnt == 6'h00);
    assign flush   = block_start_i || block_error_i;
    assign drain   = out_v_r && tx_ready_i;

    // occupancy after this cycle, so the registered ready never overfills
    always_comb begin
        cnt_nxt = cnt;
        if (flush) begin
            cnt_nxt = 6'h00;
        end else if (push && !pop) begin
            cnt_nxt = cnt + 6'h01;
        end else if (pop && !push) begin
            cnt_nxt = cnt - 6'h01;
        end
    end

    // software-writable registers
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cmd_r <= RST_HOST_CMD;
            own_r <= RST_OWN_ADDR;
            mon_r <= RST_MON_ADDR;
        end else if (io_wr_i) begin
            if (sel(io_addr_i, OFF_HOST_CMD)) begin
                cmd_r <= io_wdata_i;
            end
            if (sel(io_addr_i, OFF_OWN_ADDR)) begin
                own_r <= {io_wdata_i[7:1], 1'b0};   // bit 0 reserved, reads zero
            end
            if (sel(io_addr_i, OFF_MON_ADDR)) begin
                mon_r <= {io_wdata_i[7:1], 1'b0};
            end
        end
    end

    assign host_command_o = cmd_r;

    // start strobe and block count latched together
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            host_go_o     <= 1'b0;
            block_count_o <= RST_COUNT;
        end else begin
            host_go_o <= host_go_req_i && !host_busy_i;
            if (host_go_req_i && !host_busy_i) begin
                block_count_o <= host_data_i[COUNT_MSB:0];
            end
        end
    end

    // fifo storage; no reset needed, pointers decide what is valid
    always_ff @(posedge clk_i) begin
        if (push && !flush) begin
            mem[wptr_r[PTR_W-2:0]] <= push_d;
        end
    end

    // fifo pointers; a flush wins over any access in the same cycle
    always_ff @(posedge clk_i) begin
        if (reset_i || flush) begin
            wptr_r     <= '0;
            rptr_r     <= '0;
            rx_ready_r <= 1'b0;
        end else begin
            if (push) begin
                wptr_r <= wptr_r + 6'h01;
            end
            if (pop) begin
                rptr_r <= rptr_r + 6'h01;
            end
            rx_ready_r <= (cnt_nxt != FIFO_FULL_CNT);
        end
    end

    assign rx_ready_o = rx_ready_r;

    // a block read fills the fifo for software; without this mark the
    // transmitter would drain the received bytes before software sees them
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rd_mode_r <= 1'b0;
        end else if (block_start_i) begin
            rd_mode_r <= 1'b1;
        end else if (!host_busy_i) begin
            rd_mode_r <= 1'b0;
        end
    end

    // two-entry buffer toward the transmitter; the skid slot catches
    // the byte already popped when the receiver stalls
    always_ff @(posedge clk_i) begin
        if (reset_i || flush) begin
            out_v_r  <= 1'b0;
            out_d_r  <= RST_RDATA;
            skid_v_r <= 1'b0;
            skid_d_r <= RST_RDATA;
        end else if (!out_v_r || drain) begin
            if (skid_v_r) begin
                out_v_r  <= 1'b1;
                out_d_r  <= skid_d_r;
                skid_v_r <= 1'b0;
            end else begin
                out_v_r  <= tx_pop;
                out_d_r  <= pop_d;
            end
        end else if (tx_pop) begin
            skid_v_r <= 1'b1;
            skid_d_r <= pop_d;
        end
    end

    assign tx_valid_o = out_v_r;
    assign tx_data_o  = out_d_r;

    // register read port, one cycle latency; unmapped offsets read zero
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            io_rdata_o <= RST_RDATA;
        end else if (io_rd_i) begin
            unique case (1'b1)
                sel(io_addr_i, OFF_HOST_CMD): io_rdata_o <= cmd_r;
                sel(io_addr_i, OFF_BLOCK):    io_rdata_o <= sw_pop ? pop_d : RST_RDATA;
                sel(io_addr_i, OFF_SDATA_LO): io_rdata_o <= sdata_r[7:0];
                sel(io_addr_i, OFF_SDATA_HI): io_rdata_o <= sdata_r[15:8];
                sel(io_addr_i, OFF_SADDR_LO): io_rdata_o <= saddr_r[7:0];
                sel(io_addr_i, OFF_SADDR_HI): io_rdata_o <= saddr_r[15:8];
                sel(io_addr_i, OFF_OWN_ADDR): io_rdata_o <= own_r;
                sel(io_addr_i, OFF_MON_ADDR): io_rdata_o <= mon_r;
                default:                      io_rdata_o <= RST_RDATA;
            endcase
        end
    end

    // capture request toggle crossing into the register clock
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            req_s1_r  <= 1'b0;
            req_s2_r  <= 1'b0;
            req_s3_r  <= 1'b0;
            ack_tgl_r <= 1'b0;
        end else begin
            req_s1_r  <= req_tgl_r;
            req_s2_r  <= req_s1_r;
            req_s3_r  <= req_s2_r;
            ack_tgl_r <= req_s2_r;
        end
    end

    assign cap_new = req_s2_r ^ req_s3_r;

    // cap_r is held still by the link side until acknowledged, so all
    // sixteen bits of both registers change in the same edge
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sdata_r <= RST_SDATA;
            saddr_r <= RST_SADDR;
        end else if (cap_new) begin
            sdata_r <= cap_r.data;
            saddr_r <= cap_r.addr;
        end
    end

    // sticky match flags; a new match beats a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            slv_flag_r <= 1'b0;
            mon_flag_r <= 1'b0;
        end else begin
            slv_flag_r <= (slv_flag_r && !slave_flag_clr_i)
                          || (cap_new && cap_r.slave_hit);
            mon_flag_r <= (mon_flag_r && !monitor_flag_clr_i)
                          || (cap_new && cap_r.mon_hit);
        end
    end

    assign slave_match_flag_o   = slv_flag_r;
    assign monitor_match_flag_o = mon_flag_r;

    // link-domain reset, config and acknowledge synchronisers; the address
    // registers are quasi-static, rewriting them mid-cycle is unsafe
    always_ff @(posedge link_clk_i) begin
        lrst_s1_r <= reset_i;
        lrst_s2_r <= lrst_s1_r;
        own_s1_r  <= own_r[7:1];
        own_s2_r  <= own_s1_r;
        mon_s1_r  <= mon_r[7:1];
        mon_s2_r  <= mon_s1_r;
        ack_s1_r  <= ack_tgl_r;
        ack_s2_r  <= ack_s1_r;
    end

    assign pending = (req_tgl_r != ack_s2_r);

    // bus cycle tracker: timeout, then stop, then byte, then start
    always_ff @(posedge link_clk_i) begin
        if (lrst_s2_r) begin
            lk_state_r <= LK_IDLE;
            s_hit_r    <= 1'b0;
            m_hit_r    <= 1'b0;
            wk_addr_r  <= RST_SADDR;
            wk_data_r  <= RST_SDATA;
            cap_r      <= '0;
            req_tgl_r  <= 1'b0;
        end else if (lk_timeout_i) begin
            lk_state_r <= LK_IDLE;
            s_hit_r    <= 1'b0;
            m_hit_r    <= 1'b0;
        end else if (lk_stop_i) begin
            // a capture still in flight is kept; the later one is lost
            if ((s_hit_r || m_hit_r) && !pending && lk_state_r != LK_IDLE) begin
                cap_r     <= '{data: wk_data_r, addr: wk_addr_r,
                               slave_hit: s_hit_r, mon_hit: m_hit_r};
                req_tgl_r <= !req_tgl_r;
            end
            lk_state_r <= LK_IDLE;
            s_hit_r    <= 1'b0;
            m_hit_r    <= 1'b0;
        end else if (lk_byte_valid_i) begin
            unique case (lk_state_r)
                LK_IDLE, LK_REST: begin
                end
                LK_ADDR: begin
                    s_hit_r <= (lk_byte_i[7:1] == own_s2_r) && !lk_byte_i[DIR_BIT];
                    m_hit_r <= (lk_byte_i[7:1] == mon_s2_r) && (mon_s2_r != own_s2_r);
                    lk_state_r <= LK_CMD;
                end
                LK_CMD: begin
                    if (m_hit_r) begin
                        wk_addr_r[7:0] <= lk_byte_i;
                    end else begin
                        wk_addr_r[7:0] <= {lk_byte_i[7:1], 1'b0};
                    end
                    if (s_hit_r && lk_byte_i[7:3] == TEN_BIT_PFX) begin
                        lk_state_r <= LK_EXT;
                    end else begin
                        lk_state_r <= LK_DLO;
                    end
                end
                LK_EXT: begin
                    wk_addr_r[15:8] <= lk_byte_i;
                    lk_state_r      <= LK_DLO;
                end
                LK_DLO: begin
                    wk_data_r[7:0] <= lk_byte_i;
                    lk_state_r     <= LK_DHI;
                end
                LK_DHI: begin
                    wk_data_r[15:8] <= lk_byte_i;
                    lk_state_r      <= LK_REST;
                end
                default: begin
                    lk_state_r <= LK_IDLE;
                end
            endcase
        end else if (lk_start_i) begin
            lk_state_r <= LK_ADDR;
            s_hit_r    <= 1'b0;
            m_hit_r    <= 1'b0;
            wk_addr_r  <= RST_SADDR;
            wk_data_r  <= RST_SDATA;
        end
    end

endmodule

`default_nettype wire

// [sim/smbhs_asserts.sv]
// smbhs_asserts: port-level checks of the smbus host block, bound to its top
`timescale 1ns/1ns
`default_nettype none
module smbhs_asserts
    import smbhs_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic [7:0]  io_addr_i,
    input  wire logic        io_wr_i,
    input  wire logic        io_rd_i,
    input  wire logic [7:0]  io_wdata_i,
    input  wire logic [7:0]  io_rdata_o,
    input  wire logic        host_busy_i,
    input  wire logic        host_go_req_i,
    input  wire logic [15:0] host_data_i,
    input  wire logic        block_start_i,
    input  wire logic        block_error_i,
    input  wire logic        host_go_o,
    input  wire logic [7:0]  host_command_o,
    input  wire logic [5:0]  block_count_o,
    input  wire logic        tx_valid_o,
    input  wire logic [7:0]  tx_data_o,
    input  wire logic        tx_ready_i,
    input  wire logic        slave_match_flag_o,
    input  wire logic        slave_flag_clr_i
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    // accepted start and a block port read under busy
    sequence s_go;
        host_go_req_i && !host_busy_i;
    endsequence
    sequence s_blk_rd;
        io_rd_i && io_addr_i == OFF_BLOCK && host_busy_i;
    endsequence

    property p_go;
        s_go |=> host_go_o;
    endproperty
    a_go: assert property (p_go) else $error("start not issued");
    property p_go_busy;
        host_go_req_i && host_busy_i |=> !host_go_o;
    endproperty
    a_go_busy: assert property (p_go_busy) else $error("start taken while busy");
    property p_count;
        s_go |=> block_count_o == 6'($past(host_data_i));
    endproperty
    a_count: assert property (p_count) else $error("block count wrong");
    property p_cmd;
        io_wr_i && io_addr_i == OFF_HOST_CMD |=> host_command_o == $past(io_wdata_i);
    endproperty
    a_cmd: assert property (p_cmd) else $error("command byte not offered");
    property p_busy_rd;
        s_blk_rd |=> io_rdata_o == 8'h00;
    endproperty
    a_busy_rd: assert property (p_busy_rd) else $error("port read while busy");
    property p_err;
        block_error_i |=> !tx_valid_o;
    endproperty
    a_err: assert property (p_err) else $error("byte left after error");
    property p_new;
        block_start_i |=> !tx_valid_o;
    endproperty
    a_new: assert property (p_new) else $error("stale byte after start");
    // a stalled byte must not be lost or changed
    property p_tx_hold;
        tx_valid_o && !tx_ready_i && !block_start_i && !block_error_i
            |=> tx_valid_o && $stable(tx_data_o);
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("stalled byte dropped");
    property p_slv_sticky;
        slave_match_flag_o && !slave_flag_clr_i |=> slave_match_flag_o;
    endproperty
    a_slv_sticky: assert property (p_slv_sticky) else $error("slave flag lost");
endmodule

bind smbhs_top smbhs_asserts smbhs_asserts_i (
    .clk_i, .reset_i, .io_addr_i, .io_wr_i, .io_rd_i, .io_wdata_i, .io_rdata_o,
    .host_busy_i, .host_go_req_i, .host_data_i, .block_start_i, .block_error_i,
    .host_go_o, .host_command_o, .block_count_o, .tx_valid_o, .tx_data_o,
    .tx_ready_i, .slave_match_flag_o, .slave_flag_clr_i
);
`default_nettype wire

// [sim/smbhs_link_model.sv]
// smbhs_link_model: bus master on the link side playing whole snooped cycles
`timescale 1ns/1ns
`default_nettype none
module smbhs_link_model (
    input  wire logic       link_clk_i,
    output logic            lk_start_o,
    output logic            lk_byte_valid_o,
    output logic      [7:0] lk_byte_o,
    output logic            lk_stop_o,
    output logic            lk_timeout_o
);
    // bus idle at time zero
    initial begin
        lk_start_o = 1'b0;
        lk_byte_valid_o = 1'b0;
        lk_byte_o = 8'h00;
        lk_stop_o = 1'b0;
        lk_timeout_o = 1'b0;
    end

    // bytes leave msb first from b; gap slows the master down between bytes
    task automatic frame(input logic [39:0] b, input int n, input logic to, input int gap);
        @(posedge link_clk_i);
        lk_start_o <= 1'b1;
        @(posedge link_clk_i);
        lk_start_o <= 1'b0;
        for (int i = 0; i < n; i++) begin
            repeat (gap + 1) @(posedge link_clk_i);
            lk_byte_valid_o <= 1'b1;
            lk_byte_o <= b[39-8*i -: 8];
            @(posedge link_clk_i);
            lk_byte_valid_o <= 1'b0;
            lk_byte_o <= ~b[39-8*i -: 8]; // no stale byte once released
        end
        @(posedge link_clk_i);
        lk_stop_o <= !to;
        lk_timeout_o <= to;
        @(posedge link_clk_i);
        lk_stop_o <= 1'b0;
        lk_timeout_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

// [sim/testbench.sv]
// testbench: self-checking bench for the smbus host block with a link-side master
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import smbhs_pkg::*;
    logic        clk_i = 1'b0, link_clk_i = 1'b0, reset_i = 1'b1;
    logic [7:0]  io_addr_i = 8'h00, io_wdata_i = 8'h00, io_rdata_o;
    logic        io_wr_i = 1'b0, io_rd_i = 1'b0;
    logic        host_busy_i = 1'b0, host_go_req_i = 1'b0, host_go_o;
    logic [15:0] host_data_i = 16'h0000;
    logic        block_start_i = 1'b0, block_error_i = 1'b0;
    logic [7:0]  host_command_o, tx_data_o, lk_byte_i, rx_data_i = 8'h00;
    logic [5:0]  block_count_o;
    logic        tx_valid_o, tx_ready_i = 1'b0, rx_valid_i = 1'b0, rx_ready_o;
    logic        lk_start_i, lk_byte_valid_i, lk_stop_i, lk_timeout_i;
    logic        slave_match_flag_o, monitor_match_flag_o;
    logic        slave_flag_clr_i = 1'b0, monitor_flag_clr_i = 1'b0;
    int          failures = 0, total_checks = 0, cyc = 0;
    int          seed = 32'h7459;
    logic        rd_d = 1'b0;
    logic [7:0]  rdq[$], txq[$], rxq[$];
    logic [7:0]  v, dl, dh;

    smbhs_top smbhs_top_i (.*);
    smbhs_link_model smbhs_link_model_i (.link_clk_i, .lk_start_o(lk_start_i),
        .lk_byte_valid_o(lk_byte_valid_i), .lk_byte_o(lk_byte_i),
        .lk_stop_o(lk_stop_i), .lk_timeout_o(lk_timeout_i));

    // link clock free of any phase relation to the register clock
    always #20 clk_i = ~clk_i;
    initial #7 forever #15 link_clk_i = ~link_clk_i;

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic summarize;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        io_addr_i <= a;
        io_wdata_i <= d;
        io_wr_i <= 1'b1;
        @(posedge clk_i);
        io_wr_i <= 1'b0;
    endtask
    // expectation is queued; the watcher compares when the data appears
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i);
        io_addr_i <= a;
        io_rd_i <= 1'b1;
        rdq.push_back(e);
        @(posedge clk_i);
        io_rd_i <= 1'b0;
    endtask
    // clear flags, then let the link master play a cycle and the capture settle
    task automatic frame(input logic [39:0] b, input int n, input logic to);
        @(posedge clk_i);
        slave_flag_clr_i <= 1'b1;
        monitor_flag_clr_i <= 1'b1;
        @(posedge clk_i);
        slave_flag_clr_i <= 1'b0;
        monitor_flag_clr_i <= 1'b0;
        smbhs_link_model_i.frame(b, n, to, {$random(seed)} % 3);
        repeat (14) @(posedge clk_i);
    endtask

    // watcher: read data one cycle after the read edge, tx bytes on handshake
    always @(posedge clk_i) begin
        if (rd_d) chk("io_rdata_o", rdq.pop_front(), io_rdata_o);
        rd_d <= io_rd_i;
        if (tx_valid_o && tx_ready_i) chk("tx_data_o", txq.pop_front(), tx_data_o);
        cyc++;
        if (cyc == 20000) begin
            failures++;
            summarize();
        end
    end

    initial begin
        repeat (8) @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        for (int i = 0; i < 9; i++) rd(8'he8 + 8'(i), (i > 5 && i < 8) ? 8'h10 : 8'h00);
        v = $random(seed);
        wr(OFF_HOST_CMD, v);
        rd(OFF_HOST_CMD, v);
        chk("host_command_o", v, host_command_o);
        wr(OFF_OWN_ADDR, 8'h5b);
        rd(OFF_OWN_ADDR, 8'h5a);
        wr(OFF_OWN_ADDR, 8'h10);
        wr(OFF_SDATA_LO, 8'hff);
        rd(OFF_SDATA_LO, 8'h00);
        // block write: 33rd byte refused, stalled engine drains the rest
        for (int i = 0; i < 33; i++) begin
            v = $random(seed);
            wr(OFF_BLOCK, v);
            if (i < 32) txq.push_back(v);
        end
        @(posedge clk_i);
        host_go_req_i <= 1'b1;
        host_data_i <= {10'($random(seed)), 6'h20};
        @(posedge clk_i);
        host_go_req_i <= 1'b0;
        @(posedge clk_i);
        chk("host_go_o", 1, host_go_o);
        chk("block_count_o", 6'h20, block_count_o);
        host_busy_i <= 1'b1;
        host_go_req_i <= 1'b1;
        @(posedge clk_i);
        host_go_req_i <= 1'b0;
        @(posedge clk_i);
        chk("host_go_o", 0, host_go_o);
        wr(OFF_BLOCK, 8'hee);
        rd(OFF_BLOCK, 8'h00);
        for (int i = 0; i < 400 && txq.size() > 0; i++) begin
            @(posedge clk_i);
            tx_ready_i <= 1'($random(seed));
        end
        repeat (4) @(posedge clk_i);
        chk("tx_valid_o", 0, tx_valid_o);
        host_busy_i <= 1'b0;
        tx_ready_i <= 1'b0;
        rd(OFF_BLOCK, 8'h00);
        // block read of 32 bytes, fifo refuses the 33rd
        @(posedge clk_i);
        host_busy_i <= 1'b1;
        block_start_i <= 1'b1;
        @(posedge clk_i);
        block_start_i <= 1'b0;
        for (int i = 0; i < 32; i++) begin
            v = $random(seed);
            rxq.push_back(v);
            rx_valid_i <= 1'b1;
            rx_data_i <= v;
            do @(posedge clk_i); while (!rx_ready_o);
        end
        rx_data_i <= ~v;
        repeat (2) @(posedge clk_i);
        chk("rx_ready_o", 0, rx_ready_o);
        rd(OFF_BLOCK, 8'h00);
        rx_valid_i <= 1'b0;
        host_busy_i <= 1'b0;
        for (int i = 0; i < 32; i++) rd(OFF_BLOCK, rxq[i]);
        // error flush, then new-cycle flush
        for (int k = 0; k < 2; k++) begin
            wr(OFF_BLOCK, 8'h3c);
            @(posedge clk_i);
            block_error_i <= (k == 0);
            block_start_i <= (k == 1);
            @(posedge clk_i);
            block_error_i <= 1'b0;
            block_start_i <= 1'b0;
            rd(OFF_BLOCK, 8'h00);
        end
        // own address write cycle, then a read to it, then a timed-out one
        dl = $random(seed);
        dh = $random(seed);
        frame({8'h10, 8'ha7, dl, dh, 8'h00}, 4, 1'b0);
        chk("slave_flag", 1, slave_match_flag_o);
        chk("monitor_flag", 0, monitor_match_flag_o);
        rd(OFF_SDATA_LO, dl);
        rd(OFF_SDATA_HI, dh);
        rd(OFF_SADDR_LO, 8'ha6);
        frame({8'h11, 8'ha7, dl, dh, 8'h00}, 4, 1'b0);
        chk("slave_flag", 0, slave_match_flag_o);
        frame({8'h10, 8'ha7, dl, dh, 8'h00}, 4, 1'b1);
        chk("slave_flag", 0, slave_match_flag_o);
        frame({8'h10, 8'hf2, 8'h9c, dh, dl}, 5, 1'b0);
        rd(OFF_SADDR_LO, 8'hf2);
        rd(OFF_SADDR_HI, 8'h9c);
        rd(OFF_SDATA_LO, dh);
        // monitor hit with read direction
        wr(OFF_MON_ADDR, 8'h40);
        frame({8'h41, 8'h35, dl, dh, 8'h00}, 4, 1'b0);
        chk("monitor_flag", 1, monitor_match_flag_o);
        chk("slave_flag", 0, slave_match_flag_o);
        rd(OFF_SDATA_LO, dl);
        rd(OFF_SDATA_HI, dh);
        rd(OFF_SADDR_LO, 8'h35);
        repeat (4) @(posedge clk_i);
        summarize();
    end
endmodule
`default_nettype wire
